// file: rtc_ctl_pkg.sv
package rtc_ctl_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_COUNTDOWN = 8'h0C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_RUN_BIT = 7;
  localparam int CTL_SOFT_RESET_BIT = 0;
  localparam int FLAG_HOUR = 5;
  localparam int FLAG_SECOND = 4;
  localparam int FLAG_DAY = 3;
  localparam int FLAG_ALARM = 2;
  localparam int FLAG_MINUTE = 1;
  localparam int FLAG_COUNTDOWN = 0;
  localparam int FLAG_W = 6;
  localparam int COUNT_W = 6;
  localparam int HOUR_W = 5;

  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
  localparam logic [FLAG_W-1:0] MASK_RESET = 6'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 6'h3F;
  localparam logic [COUNT_W-1:0] COUNT_EXPIRED = 6'h3F;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 6'h01;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 6'h00;
  localparam logic [HOUR_W-1:0] HOUR_LAST = 5'h17;
  localparam logic [HOUR_W-1:0] HOUR_FIRST = 5'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS
  } apb_state_t;

endpackage

// file: rtc_control_and_event_flags.sv
// Functional notes
// RULE1: run-enable bit 7 of control runs the clock when 1, stops it when 0.
// RULE2: writing 1 to control bit 0 resets the module; 0 does nothing.
// RULE3: module soft reset leaves the run-enable bit untouched.
// RULE4: registers reset only at first power-on, kept through later resets.
// RULE5: events set their flag whatever the mask bit holds.
// RULE6: writing 1 to a flag clears it and its interrupt; 0 leaves it.
// RULE7: interrupts still raised while system clock idles or sleeps.
// RULE8: hour flag bit 5 sets on each hour counter increment.
// RULE9: second flag bit 4 sets on each seconds counter increment.
// RULE10: day flag bit 3 sets on each day counter increment.
// RULE11: alarm flag bit 2 sets when time equals alarm; recurs every 65536 days.
// RULE12: software wanting one alarm clears its mask bit in the handler.
// RULE13: minute flag bit 1 sets on each minute counter increment.
// RULE14: countdown flag bit 0 sets when the stopwatch times out.
// RULE15: mask bit per flag gates the interrupt, never changes the flag.
// RULE16: day event occurs when hours wrap from 23 to 0.
// RULE17: countdown decrements per minute tick, stays at -1, expiry sets flag.
// RULE18: interrupt high while any flag and its mask bit are both set.
`timescale 1ns/10ps
`default_nettype none

module rtc_control_and_event_flags (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_second_tick,
  input wire logic i_minute_tick,
  input wire logic i_hour_tick,
  input wire logic [rtc_ctl_pkg::HOUR_W-1:0] i_hour_value,
  input wire logic i_alarm_match,
  output logic o_run_enable,
  output logic o_module_soft_reset,
  output logic o_irq
);
  import rtc_ctl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  apb_state_t state;
  apb_state_t next_state;
  logic run_enable;
  logic next_run_enable;
  logic soft_reset;
  logic next_soft_reset;
  logic [FLAG_W-1:0] rtc_event_flags;
  logic [FLAG_W-1:0] next_rtc_event_flags;
  logic [FLAG_W-1:0] rtc_event_mask;
  logic [FLAG_W-1:0] next_rtc_event_mask;
  logic [COUNT_W-1:0] countdown_minutes;
  logic [COUNT_W-1:0] next_countdown_minutes;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic pready;
  logic next_pready;
  logic pslverr;
  logic next_pslverr;
  logic irq;
  logic next_irq;

  // ---------------------------------------------------------------
  // strobes
  // ---------------------------------------------------------------
  logic [FLAG_W-1:0] events;
  logic setup_take;
  logic wr_take;
  logic wr_control;
  logic wr_flags;
  logic wr_mask;
  logic wr_count;
  logic count_tick;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, ADDR_CONTROL) | hit(a, ADDR_FLAGS) | hit(a, ADDR_MASK)
      | hit(a, ADDR_COUNTDOWN);
  endfunction

  // ---------------------------------------------------------------
  // event capture
  // ---------------------------------------------------------------
  // ticks only count while running; the counters outside stop too
  always_comb begin
    events = '0;
    events[FLAG_SECOND] = run_enable & i_second_tick; // see RULE9 see RULE1
    events[FLAG_MINUTE] = run_enable & i_minute_tick; // see RULE13
    events[FLAG_HOUR] = run_enable & i_hour_tick; // see RULE8
    // day ticks on the 23 to 0 wrap
    events[FLAG_DAY] = run_enable & i_hour_tick
      & (i_hour_value == HOUR_FIRST); // see RULE10 see RULE16
    events[FLAG_ALARM] = run_enable & i_alarm_match; // see RULE11
    // expiry is the step from 0 to -1 on a minute tick
    events[FLAG_COUNTDOWN] = count_tick
      & (countdown_minutes == COUNT_ZERO); // see RULE14 see RULE17
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign count_tick = run_enable & i_minute_tick;
  assign setup_take = (state == ST_IDLE) & i_psel & ~i_penable;
  // a write lands only on the access edge, while ready is high
  assign wr_take = (state == ST_ACCESS) & i_psel & i_penable & i_pwrite;
  assign wr_control = wr_take & hit(i_paddr, ADDR_CONTROL);
  assign wr_flags = wr_take & hit(i_paddr, ADDR_FLAGS);
  assign wr_mask = wr_take & hit(i_paddr, ADDR_MASK);
  assign wr_count = wr_take & hit(i_paddr, ADDR_COUNTDOWN);

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // no wait states: ready follows setup by one cycle, so read data are
  // fetched at setup and stand through the access cycle
  always_comb begin
    next_state = state;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    case (state)
      ST_IDLE: begin
        if (setup_take) begin
          next_state = ST_ACCESS;
          next_pready = 1'b1;
          // unmapped: write dropped, read gives zero
          next_pslverr = ~mapped(i_paddr);
          next_prdata = READ_ZERO;
          if (!i_pwrite) begin
            if (hit(i_paddr, ADDR_CONTROL)) begin
              next_prdata[CTL_RUN_BIT] = run_enable;
            end else if (hit(i_paddr, ADDR_FLAGS)) begin
              next_prdata[FLAG_W-1:0] = rtc_event_flags;
            end else if (hit(i_paddr, ADDR_MASK)) begin
              next_prdata[FLAG_W-1:0] = rtc_event_mask;
            end else if (hit(i_paddr, ADDR_COUNTDOWN)) begin
              next_prdata[COUNT_W-1:0] = countdown_minutes;
            end
          end
        end
      end
      ST_ACCESS: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // control: run enable and soft reset strobe
  // ---------------------------------------------------------------
  always_comb begin
    next_run_enable = run_enable;
    next_soft_reset = 1'b0;
    if (wr_control) begin
      next_run_enable = i_pwdata[CTL_RUN_BIT]; // see RULE1
      // a 0 in the reset bit does nothing
      next_soft_reset = i_pwdata[CTL_SOFT_RESET_BIT]; // see RULE2
    end
    // the soft reset never reaches run enable
    if (soft_reset) begin
      next_run_enable = run_enable; // see RULE3
    end
  end

  // ---------------------------------------------------------------
  // event flags
  // ---------------------------------------------------------------
  always_comb begin
    next_rtc_event_flags = rtc_event_flags;
    if (wr_flags) begin
      next_rtc_event_flags = rtc_event_flags & ~i_pwdata[FLAG_W-1:0]; // see RULE6
    end
    // set beats clear, so an event racing the clear is never lost
    next_rtc_event_flags = next_rtc_event_flags | events; // see RULE5 see RULE15
    if (soft_reset) begin
      next_rtc_event_flags = FLAGS_RESET; // see RULE2
    end
  end

  // ---------------------------------------------------------------
  // interrupt mask
  // ---------------------------------------------------------------
  always_comb begin
    next_rtc_event_mask = rtc_event_mask;
    if (wr_mask) begin
      next_rtc_event_mask = i_pwdata[FLAG_W-1:0]; // see RULE15
    end
    if (soft_reset) begin
      next_rtc_event_mask = MASK_RESET; // see RULE2
    end
  end

  // ---------------------------------------------------------------
  // countdown minutes
  // ---------------------------------------------------------------
  // parks at -1 until reprogrammed; a write in the same cycle wins
  always_comb begin
    next_countdown_minutes = countdown_minutes;
    if (wr_count) begin
      next_countdown_minutes = i_pwdata[COUNT_W-1:0];
    end else if (count_tick && countdown_minutes != COUNT_EXPIRED) begin
      next_countdown_minutes = countdown_minutes - COUNT_ONE; // see RULE17
    end
    if (soft_reset) begin
      next_countdown_minutes = COUNT_RESET; // see RULE2
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  // built from next values so the line moves with the flag, not a cycle late
  always_comb begin
    next_irq = |(next_rtc_event_flags & next_rtc_event_mask); // see RULE18 see RULE15
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // time-keeping state sits on the power-on reset only; system resets
  // must not wipe it, so i_rst_n touches only the bus handshake
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      prdata <= READ_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // run enable clears only on power-on
  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      run_enable <= 1'b0; // see RULE4
      soft_reset <= 1'b0;
    end else begin
      run_enable <= next_run_enable;
      soft_reset <= next_soft_reset;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      rtc_event_flags <= FLAGS_RESET;
    end else begin
      rtc_event_flags <= next_rtc_event_flags;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      rtc_event_mask <= MASK_RESET;
    end else begin
      rtc_event_mask <= next_rtc_event_mask;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      countdown_minutes <= COUNT_RESET;
    end else begin
      countdown_minutes <= next_countdown_minutes;
    end
  end

  // registered so the pin never shows a decode glitch
  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq; // see RULE7
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign o_run_enable = run_enable;
  assign o_module_soft_reset = soft_reset;
  assign o_irq = irq;

endmodule // rtc_control_and_event_flags

`default_nettype wire

// file: rtc_ctl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_ctl_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_run_enable,
  input wire logic o_module_soft_reset,
  input wire logic o_irq
);
  import rtc_ctl_pkg::*;
  logic wr_ctl;
  logic addr_ok;
  assign addr_ok = i_paddr inside {ADDR_CONTROL, ADDR_FLAGS, ADDR_MASK, ADDR_COUNTDOWN};
  assign wr_ctl = i_psel && i_penable && o_pready && i_pwrite && i_paddr == ADDR_CONTROL;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_por_n || !i_rst_n);
  a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (o_pready |-> (o_pslverr == !addr_ok)
    && (!o_pslverr || o_prdata == READ_ZERO)) else $error("bad error response");
  a_run_write:
    assert property (wr_ctl |=> o_run_enable == $past(i_pwdata[CTL_RUN_BIT]))
    else $error("run enable not written");
  a_soft_write:
    assert property (wr_ctl && i_pwdata[CTL_SOFT_RESET_BIT] |=> o_module_soft_reset)
    else $error("soft reset missing");
  a_soft_cause:
    assert property (o_module_soft_reset |-> $past(wr_ctl) && $past(i_pwdata[CTL_SOFT_RESET_BIT]))
    else $error("soft reset without write");
  a_soft_keep_run: assert property (o_module_soft_reset |=> $stable(o_run_enable))
    else $error("soft reset moved run enable");
  a_soft_irq_low: assert property (o_module_soft_reset |=> !o_irq)
    else $error("irq after soft reset");
  c_soft: cover property (o_module_soft_reset);
  c_irq: cover property ($rose(o_irq));
  c_err: cover property (o_pready && o_pslverr);
endmodule // rtc_ctl_chk
bind rtc_control_and_event_flags rtc_ctl_chk chk_u (.i_ref_clk, .i_rst_n, .i_por_n, .i_paddr,
  .i_psel, .i_penable, .i_pwrite, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_run_enable,
  .o_module_soft_reset, .o_irq);
`default_nettype wire

// file: rtc_control_and_event_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module rtc_control_and_event_flags_tb;
  import rtc_ctl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic pready, pslverr, run, module_soft_reset, irq, err;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prdata, rdat;
  logic [3:0] ev = 4'h0;
  logic [HOUR_W-1:0] hv = 5'h00;
  int error_cnt = 0, n_tests = 0;
  rtc_control_and_event_flags dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
    .i_paddr(pa), .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_pwdata(pwd),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_second_tick(ev[0]),
    .i_minute_tick(ev[1]), .i_hour_tick(ev[2]), .i_hour_value(hv), .i_alarm_match(ev[3]),
    .o_run_enable(run), .o_module_soft_reset(module_soft_reset), .o_irq(irq));
  initial begin
    forever #10 clk = ~clk;
  end
  // idle cycle after each transfer keeps every driver to one update per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rdat)
  endtask
  task automatic pulse(input logic [3:0] v, input logic [HOUR_W-1:0] h);
    ev <= v;
    hv <= h;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_MASK, 32'h0);
    rd(ADDR_COUNTDOWN, 32'h3F);
    pulse(4'hF, 5'h00);
    rd(ADDR_FLAGS, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h80);
    `CHK("run", 1'b1, run)
    apb(1'b1, ADDR_COUNTDOWN, 32'h1);
    pulse(4'h1, 5'h05);
    rd(ADDR_FLAGS, 32'h10);
    pulse(4'h2, 5'h05);
    rd(ADDR_FLAGS, 32'h12);
    rd(ADDR_COUNTDOWN, 32'h0);
    pulse(4'h4, 5'h05);
    rd(ADDR_FLAGS, 32'h32);
    pulse(4'h4, 5'h00);
    rd(ADDR_FLAGS, 32'h3A);
    pulse(4'h8, 5'h00);
    rd(ADDR_FLAGS, 32'h3E);
    pulse(4'h2, 5'h00);
    rd(ADDR_FLAGS, 32'h3F);
    rd(ADDR_COUNTDOWN, 32'h3F);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, ADDR_MASK, 32'h1);
    rd(ADDR_MASK, 32'h1);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, ADDR_FLAGS, 32'h3E);
    rd(ADDR_FLAGS, 32'h1);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, ADDR_FLAGS, 32'h1);
    rd(ADDR_FLAGS, 32'h0);
    `CHK("irq", 1'b0, irq)
    rd(8'h10, 32'h0);
    `CHK("pslverr", 1'b1, err)
    pulse(4'h1, 5'h00);
    apb(1'b1, ADDR_CONTROL, 32'h80);
    rd(ADDR_FLAGS, 32'h10);
    apb(1'b1, ADDR_MASK, 32'h3F);
    rd(ADDR_MASK, 32'h3F);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, ADDR_COUNTDOWN, 32'h5);
    apb(1'b1, ADDR_CONTROL, 32'h81);
    rd(ADDR_FLAGS, 32'h0);
    rd(ADDR_MASK, 32'h0);
    rd(ADDR_CONTROL, 32'h80);
    rd(ADDR_COUNTDOWN, 32'h3F);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, ADDR_MASK, 32'h4);
    pulse(4'h8, 5'h00);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, ADDR_MASK, 32'h0);
    apb(1'b1, ADDR_FLAGS, 32'h4);
    pulse(4'h8, 5'h00);
    `CHK("irq", 1'b0, irq)
    rd(ADDR_FLAGS, 32'h4);
    apb(1'b1, ADDR_MASK, 32'h4);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CONTROL, 32'h80);
    rd(ADDR_MASK, 32'h4);
    rd(ADDR_FLAGS, 32'h4);
    `CHK("irq", 1'b1, irq)
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule // rtc_control_and_event_flags_tb
`default_nettype wire
